// ===== hdl/cgm_pkg.sv
// Constants, register layouts and types of the clock generator
package cgm_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] ADDR_CTRL_ONE  = 3'h0;
  localparam logic [2:0] ADDR_CTRL_TWO  = 3'h1;
  localparam logic [2:0] ADDR_TRIM      = 3'h2;
  localparam logic [2:0] ADDR_STATUS    = 3'h3;
  localparam logic [2:0] ADDR_CTRL_FOUR = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STAT  = 3'h6;
  localparam logic [2:0] ADDR_IRQ_MASK  = 3'h7;

  // ----------------------------------------
  // Reset values and fixed codes
  // ----------------------------------------
  localparam logic [7:0]  RST_CTRL_ONE  = 8'h04;
  localparam logic [7:0]  RST_CTRL_TWO  = 8'h40;
  localparam logic [7:0]  RST_CTRL_FOUR = 8'h00;
  localparam logic [11:0] DEBUG_TRIM    = 12'h800;
  localparam logic [1:0]  CLK_FLL       = 2'h0;
  localparam logic [1:0]  CLK_INT       = 2'h1;
  localparam logic [1:0]  CLK_EXT       = 2'h2;
  localparam logic [2:0]  REFERENCE_DIVIDER_FIELD_256      = 3'h3;
  localparam logic [12:0] EXT_HI_BASE   = 13'h0020;
  localparam logic [10:0] FLL_BASE      = 11'h200;

  // ----------------------------------------
  // Interrupt status bit positions
  // ----------------------------------------
  localparam int IRQ_LOCK = 0;
  localparam int IRQ_OSC  = 1;
  localparam int IRQ_REF  = 2;
  localparam int IRQ_CLK  = 3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SW_TIME_NS    = 100;
  localparam int LOCK_TIME_NS  = 1000;
  localparam int SW_CYC   = (SW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_CYC = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 3;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] system_clock_select;
    logic [2:0] reference_divider_field;
    logic       internal_ref_select_bit;
    logic [1:0] rsv;
  } cgm_ctrl_one_t;

  typedef struct packed {
    logic [1:0] bus_divider_field;
    logic       range_bit;
    logic       oscillator_high_gain_bit;
    logic       low_power_bypass_bit;
    logic       crystal_select_bit;
    logic       external_ref_enable_bit;
    logic       rsv;
  } cgm_ctrl_two_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic       low_ref_optimise_bit;
    logic [2:0] rsv_lo;
    logic [1:0] fll_range_select;
  } cgm_ctrl_four_t;

  typedef struct packed {
    logic       rsv7;
    logic       lock_flag;
    logic       rsv5;
    logic       reference_source_status;
    logic [1:0] system_clock_status;
    logic       oscillator_ready_flag;
    logic       fine_trim_bit;
  } cgm_status_t;

endpackage

// ===== hdl/cgm_clock_gen.sv
// Clock generator mode control, status, lock model and trim
`timescale 1ns/10ps
module cgm_clock_gen
  import cgm_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_osc_started,
  input  wire logic        i_debug_boot,
  input  wire logic [8:0]  i_factory_trim,
  output logic      [10:0] o_fll_factor,
  output logic      [12:0] o_ref_divisor,
  output logic      [3:0]  o_bus_divisor,
  output logic      [1:0]  o_clock_status,
  output logic             o_fll_enable,
  output logic             o_osc_enable,
  output logic             o_osc_range,
  output logic             o_osc_gain,
  output logic      [8:0]  o_irc_trim,
  output logic             o_irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [12:0] shl(input logic [12:0] base, input logic [2:0] n);
    shl = base << n;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  cgm_ctrl_one_t  c1_q;
  cgm_ctrl_two_t  c2_q;
  cgm_ctrl_four_t c4_q;
  logic [7:0]  trim_q;
  logic        fine_trim_bit_q;
  logic [3:0]  ist_q;
  logic [3:0]  imask_q;
  logic [2:0]  osc_s_q;
  logic [2:0]  dbg_s_q;
  logic        osc_f_q;
  logic        dbg_f_q;
  logic [2:0]  init_q;
  logic        osc_rdy_q;
  logic        reference_source_status_q;
  logic [1:0]  system_clock_status_q;
  logic [7:0]  sw_cnt_q;
  logic        lock_q;
  logic [15:0] lock_cnt_q;
  logic [7:0]  key_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_c1 = i_wr && (i_addr == ADDR_CTRL_ONE);
  wire wr_c2 = i_wr && (i_addr == ADDR_CTRL_TWO);
  wire wr_c4 = i_wr && (i_addr == ADDR_CTRL_FOUR);
  wire wr_tr = i_wr && (i_addr == ADDR_TRIM);
  wire wr_st = i_wr && (i_addr == ADDR_STATUS);
  wire wr_is = i_wr && (i_addr == ADDR_IRQ_STAT);
  wire wr_im = i_wr && (i_addr == ADDR_IRQ_MASK);

  cgm_status_t stat;
  assign stat = '{rsv7: 1'b0, lock_flag: lock_q, rsv5: 1'b0,
                  reference_source_status: reference_source_status_q,
                  system_clock_status: system_clock_status_q,
                  oscillator_ready_flag: osc_rdy_q,
                  fine_trim_bit: fine_trim_bit_q};

  logic [7:0] rd_mux;
  always_comb begin
    if (i_addr == ADDR_CTRL_ONE) begin
      rd_mux = c1_q;
    end else if (i_addr == ADDR_CTRL_TWO) begin
      rd_mux = c2_q;
    end else if (i_addr == ADDR_TRIM) begin
      rd_mux = trim_q;
    end else if (i_addr == ADDR_STATUS) begin
      rd_mux = stat;
    end else if (i_addr == ADDR_CTRL_FOUR) begin
      rd_mux = c4_q;
    end else if (i_addr == ADDR_IRQ_STAT) begin
      rd_mux = {4'h0, ist_q};
    end else if (i_addr == ADDR_IRQ_MASK) begin
      rd_mux = {4'h0, imask_q};
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ----------------------------------------
  // Switch-over and lock logic
  // ----------------------------------------
  wire       fll_on  = !c2_q.low_power_bypass_bit;
  wire       ref_ok  = c1_q.internal_ref_select_bit || osc_rdy_q;
  wire       ref_pnd = (c1_q.internal_ref_select_bit != reference_source_status_q) && ref_ok;
  // Reserved select code behaves as FLL
  wire [1:0] clk_tgt = (c1_q.system_clock_select == 2'h3) ? CLK_FLL : c1_q.system_clock_select;
  wire       clk_ok  = (clk_tgt == CLK_EXT) ? osc_rdy_q :
                       (clk_tgt == CLK_FLL) ? fll_on : 1'b1;
  wire       clk_pnd = (clk_tgt != system_clock_status_q) && clk_ok;
  wire       sw_done = (ref_pnd || clk_pnd) && (sw_cnt_q == 8'(SW_CYC - 1));
  // Reference first: the FLL must see its new source before being selected
  wire       ref_fire = sw_done && ref_pnd;
  wire       clk_fire = sw_done && !ref_pnd;
  wire       reference_source_status_d = ref_fire ? c1_q.internal_ref_select_bit : reference_source_status_q;
  wire [1:0] system_clock_status_d  = clk_fire ? clk_tgt : system_clock_status_q;

  // Any change of reference or factor forces a fresh lock
  wire [7:0] key_d    = {reference_source_status_d, c4_q.low_ref_optimise_bit, c4_q.fll_range_select,
                         c1_q.reference_divider_field, c2_q.range_bit};
  wire       relock   = !fll_on || (key_d != key_q);
  wire       lock_d   = !relock && (lock_cnt_q == 16'(LOCK_CYC - 1));
  wire       osc_d    = osc_f_q && c2_q.crystal_select_bit;

  wire [3:0] evt;
  assign evt[IRQ_LOCK] = lock_d && !lock_q;
  assign evt[IRQ_OSC]  = osc_d && !osc_rdy_q;
  assign evt[IRQ_REF]  = ref_fire;
  assign evt[IRQ_CLK]  = clk_fire;

  wire [1:0]  drs_eff = c4_q.fll_range_select;
  // Range 11 would need 2048, which the 11-bit factor cannot hold
  wire [10:0] fac_d   = FLL_BASE * (11'(drs_eff) + 11'h001);
  wire        ext_hi  = c2_q.range_bit && !reference_source_status_q;
  wire [12:0] reference_divider_field_d  = shl(ext_hi ? EXT_HI_BASE : 13'h0001, c1_q.reference_divider_field);
  wire [12:0] bus_divider_field_w  = shl(13'h0001, {1'b0, c2_q.bus_divider_field});
  // Nine-bit trim; higher code lengthens the oscillator period
  wire [8:0]  trim9   = {trim_q, fine_trim_bit_q};
  // Debug trim is wider than the nine-bit word; only its low bits fit
  wire [8:0]  boot_tr = dbg_f_q ? DEBUG_TRIM[8:0] : i_factory_trim;
  // Strap is trusted only after three stages and the agreement filter
  wire        trim_ld = (init_q == 3'(SYNC_CYC + 1));
  wire        init_ld = (init_q == 3'(SYNC_CYC + 2));

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_s_q <= 3'h0;
      dbg_s_q <= 3'h0;
      osc_f_q <= 1'b0;
      dbg_f_q <= 1'b0;
    end else begin
      osc_s_q <= {osc_s_q[1:0], i_osc_started};
      dbg_s_q <= {dbg_s_q[1:0], i_debug_boot};
      if (osc_s_q[1] == osc_s_q[2]) begin
        osc_f_q <= osc_s_q[2];
      end
      if (dbg_s_q[1] == dbg_s_q[2]) begin
        dbg_f_q <= dbg_s_q[2];
      end
    end
  end

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c1_q    <= RST_CTRL_ONE;
      c2_q    <= RST_CTRL_TWO;
      c4_q    <= RST_CTRL_FOUR;
      imask_q <= 4'h0;
      ist_q   <= 4'h0;
    end else begin
      if (wr_c1) begin
        c1_q <= {i_wdata[7:2], 2'h0};
      end
      if (wr_c2) begin
        c2_q <= {i_wdata[7:1], 1'b0};
      end
      if (wr_c4) begin
        c4_q <= {2'h0, i_wdata[5], 3'h0, i_wdata[1:0]};
      end
      if (wr_im) begin
        imask_q <= i_wdata[3:0];
      end
      // New events win over a simultaneous clear
      ist_q <= (ist_q & ~(wr_is ? i_wdata[3:0] : 4'h0)) | evt;
    end
  end

  // Trim is loaded once the debug strap has settled
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_q  <= 3'h0;
      trim_q  <= 8'h00;
      fine_trim_bit_q <= 1'b0;
    end else begin
      if (!init_ld) begin
        init_q <= init_q + 3'h1;
      end
      if (trim_ld) begin
        trim_q  <= boot_tr[8:1];
        fine_trim_bit_q <= boot_tr[0];
      end else begin
        if (wr_tr) begin
          trim_q <= i_wdata;
        end
        if (wr_st) begin
          fine_trim_bit_q <= i_wdata[0];
        end
      end
    end
  end

  // ----------------------------------------
  // Switch-over, lock and oscillator status
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_cnt_q   <= 8'h00;
      reference_source_status_q   <= 1'b1;
      system_clock_status_q    <= CLK_FLL;
      lock_q     <= 1'b0;
      lock_cnt_q <= 16'h0000;
      key_q      <= 8'h80;
      osc_rdy_q  <= 1'b0;
    end else begin
      sw_cnt_q   <= ((ref_pnd || clk_pnd) && !sw_done) ? sw_cnt_q + 8'h01 : 8'h00;
      reference_source_status_q   <= reference_source_status_d;
      system_clock_status_q    <= system_clock_status_d;
      key_q      <= key_d;
      lock_q     <= lock_d;
      lock_cnt_q <= (relock || lock_d) ? 16'h0000 : lock_cnt_q + 16'h0001;
      if (lock_d) begin
        lock_cnt_q <= lock_cnt_q;
      end
      osc_rdy_q  <= osc_d;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata        <= 8'h00;
      o_fll_factor   <= FLL_BASE;
      o_ref_divisor  <= 13'h0001;
      o_bus_divisor  <= 4'h1;
      o_clock_status <= CLK_FLL;
      o_fll_enable   <= 1'b0;
      o_osc_enable   <= 1'b0;
      o_osc_range    <= 1'b0;
      o_osc_gain     <= 1'b0;
      o_irc_trim     <= 9'h000;
      o_irq          <= 1'b0;
    end else begin
      o_rdata        <= i_rd ? rd_mux : 8'h00;
      o_fll_factor   <= fac_d;
      o_ref_divisor  <= reference_divider_field_d;
      o_bus_divisor  <= bus_divider_field_w[3:0];
      o_clock_status <= system_clock_status_q;
      o_fll_enable   <= fll_on;
      o_osc_enable   <= c2_q.external_ref_enable_bit || !reference_source_status_q;
      o_osc_range    <= c2_q.range_bit;
      o_osc_gain     <= c2_q.oscillator_high_gain_bit;
      o_irc_trim     <= trim9;
      o_irq          <= |(ist_q & imask_q);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_fll_runs_bypassed: assert property (!c2_q.low_power_bypass_bit |=> o_fll_enable)
    else $error("FLL not enabled with low-power bit clear");
  a_lock_restart: assert property ($changed(key_q) |-> !lock_q)
    else $error("Lock held across reference change");
  a_lock_settle: assert property ($rose(lock_q) |-> $past(lock_cnt_q) == 16'(LOCK_CYC - 1))
    else $error("Lock set before settle time");
  a_ctrl_two_fields: assert property (wr_c2 && i_wdata == 8'h36 |=> c2_q.range_bit
      && c2_q.oscillator_high_gain_bit && c2_q.crystal_select_bit && c2_q.external_ref_enable_bit)
    else $error("Control two fields not stored");
  a_osc_ready_cause: assert property ($rose(osc_rdy_q) |-> $past(osc_f_q) && $past(c2_q.crystal_select_bit))
    else $error("Oscillator ready without started crystal");
  a_fll_status: assert property ($changed(system_clock_status_q) && system_clock_status_q == CLK_FLL
      |-> $past(c1_q.system_clock_select) != CLK_INT && $past(fll_on))
    else $error("FLL status without FLL selected");
  a_ref_div_256: assert property (ext_hi && c1_q.reference_divider_field == REFERENCE_DIVIDER_FIELD_256
      |=> o_ref_divisor == 13'h0100)
    else $error("High range divider not 256");
  a_ext_ref_switch: assert property ($fell(reference_source_status_q) |-> $past(osc_rdy_q)
      && !$past(c1_q.internal_ref_select_bit))
    else $error("External reference status without ready crystal");
  a_switch_delayed: assert property ($changed(reference_source_status_q) || $changed(system_clock_status_q)
      |-> $past(sw_cnt_q) == 8'(SW_CYC - 1))
    else $error("Status changed before switch-over completed");
  a_factor_1024: assert property (c4_q.fll_range_select == 2'h1 |=> o_fll_factor == 11'h400)
    else $error("Range 01 factor not 1024");
  a_factor_512: assert property (c4_q.fll_range_select == 2'h0 |=> o_fll_factor == 11'h200)
    else $error("Default factor not 512");

  // ----------------------------------------
  // Assertions: trim, lock, clock, oscillator and interrupts
  // ----------------------------------------
  a_boot_trim_load: assert property (trim_ld |=> trim9 == $past(boot_tr))
    else $error("Boot trim not loaded");
  a_debug_trim: assert property (trim_ld && dbg_f_q |=> trim9 == DEBUG_TRIM[8:0])
    else $error("Debug boot trim not taken");
  a_trim_write: assert property (wr_tr && !trim_ld |=> trim_q == $past(i_wdata))
    else $error("Trim register write lost");
  a_fine_trim_write: assert property (wr_st && !trim_ld |=> fine_trim_bit_q == $past(i_wdata[0]))
    else $error("Fine trim bit write lost");
  a_trim_out: assert property (1'b1 |=> o_irc_trim == $past(trim9))
    else $error("Trim output not the nine-bit word");
  a_fll_off_unlock: assert property (!fll_on |=> !lock_q)
    else $error("Lock held with FLL disabled");
  a_fll_enable_off: assert property (c2_q.low_power_bypass_bit |=> !o_fll_enable)
    else $error("FLL enabled with low-power bit set");
  a_fll_source: assert property (clk_fire && c1_q.system_clock_select == CLK_FLL |=> system_clock_status_q == CLK_FLL)
    else $error("FLL select did not reach clock status");
  a_osc_needs_crystal: assert property (!c2_q.crystal_select_bit |=> !osc_rdy_q)
    else $error("Oscillator ready without crystal select");
  a_osc_range_pin: assert property (1'b1 |=> o_osc_range == $past(c2_q.range_bit))
    else $error("Range pin out of step");
  a_clock_status_pin: assert property (1'b1 |=> o_clock_status == $past(system_clock_status_q))
    else $error("Clock status pin out of step");
  a_bus_div_one: assert property (c2_q.bus_divider_field == 2'h0 |=> o_bus_divisor == 4'h1)
    else $error("Bus divider code 00 not one");
  // The lock event must never be lost to a clear in the same cycle
  a_irq_set_wins: assert property (evt[IRQ_LOCK] |=> ist_q[IRQ_LOCK])
    else $error("Lock event lost against clear");
  a_irq_level: assert property (|(ist_q & imask_q) |=> o_irq)
    else $error("Interrupt not raised for unmasked status");

  c_lock_gained: cover property ($rose(lock_q));
  c_debug_trim: cover property (trim_ld && dbg_f_q);
  c_factor_1024_lock: cover property (o_fll_factor == 11'h400 && $rose(lock_q));
  c_to_external: cover property ($fell(reference_source_status_q));
  c_fll_engaged: cover property ($changed(system_clock_status_q) && system_clock_status_q == CLK_FLL && !reference_source_status_q);

endmodule

// ===== verification/cgm_xtal_model.sv
// Crystal oscillator model that reports start-up to the clock generator
`timescale 1ns/10ps
module cgm_xtal_model #(
  parameter int START_CYC = 20
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_enable,
  output logic      o_started
);
  int count_q;

  // ----------------------------------------
  // Start-up delay
  // ----------------------------------------
  // Start-up takes time; losing enable stops the crystal at once
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q   <= 0;
      o_started <= 1'b0;
    end else if (!i_enable) begin
      count_q   <= 0;
      o_started <= 1'b0;
    end else if (count_q < START_CYC) begin
      count_q <= count_q + 1;
    end else begin
      o_started <= 1'b1;
    end
  end
endmodule

// ===== verification/test_cgm_clock_gen.sv
// Register-level testbench of the clock generator mode walk and trim
`timescale 1ns/10ps
module test_cgm_clock_gen;
  import cgm_pkg::*;
  localparam logic [8:0] FACTORY_TRIM = 9'h155;
  logic        i_clock, i_rst_n, i_wr, i_rd, i_debug_boot, xtal_started;
  logic [2:0]  i_addr;
  logic [7:0]  i_wdata, o_rdata;
  logic [10:0] o_fll_factor;
  logic [12:0] o_ref_divisor;
  logic [3:0]  o_bus_divisor;
  logic [1:0]  o_clock_status;
  logic        o_fll_enable, o_osc_enable, o_osc_range, o_osc_gain, o_irq;
  logic [8:0]  o_irc_trim;
  int          mismatches;
  int          cmp_count;
  logic [8:0]  trim_tab [3];

  cgm_clock_gen i_cgm_clock_gen (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_osc_started(xtal_started), .i_debug_boot(i_debug_boot),
    .i_factory_trim(FACTORY_TRIM), .o_fll_factor(o_fll_factor), .o_ref_divisor(o_ref_divisor),
    .o_bus_divisor(o_bus_divisor), .o_clock_status(o_clock_status), .o_fll_enable(o_fll_enable),
    .o_osc_enable(o_osc_enable), .o_osc_range(o_osc_range), .o_osc_gain(o_osc_gain),
    .o_irc_trim(o_irc_trim), .o_irq(o_irq));

  cgm_xtal_model i_cgm_xtal_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_enable(o_osc_enable),
    .o_started(xtal_started));

  // ----------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // Whole walk needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    mismatches++;
    conclude();
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic rchk(input string name, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, {8'h00, v}, {8'h00, exp});
  endtask

  // Bounded wait for a status pattern; the last value read is judged
  task automatic poll(input string name, input logic [7:0] msk, input logic [7:0] val);
    logic [7:0] v;
    for (int n = 0; n < 400; n++) begin
      rd(ADDR_STATUS, v);
      if ((v & msk) === val) break;
    end
    chk(name, {8'h00, v & msk}, {8'h00, val});
  endtask

  // ----------------------------------------
  // Mode walk
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 3'h0;
    i_wdata = 8'h00;
    i_debug_boot = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    trim_tab = '{9'h1FF, 9'h100, 9'h001};
    tick(16);
    i_rst_n <= 1'b1;
    // Trim settles only once the debug strap has passed its filter
    tick(8);
    rchk("status reset", ADDR_STATUS, 8'h11);
    rchk("trim reset", ADDR_TRIM, 8'hAA);
    chk("irc trim reset", {7'h00, o_irc_trim}, {7'h00, FACTORY_TRIM});
    rchk("ctrl one reset", ADDR_CTRL_ONE, RST_CTRL_ONE);
    rchk("ctrl two reset", ADDR_CTRL_TWO, RST_CTRL_TWO);
    rchk("ctrl four reset", ADDR_CTRL_FOUR, 8'h00);
    chk("factor reset", {5'h00, o_fll_factor}, 16'h0200);
    chk("bus div reset", {12'h000, o_bus_divisor}, 16'h0002);
    poll("first lock", 8'h40, 8'h40);
    // Walk down to the bypassed low-power internal mode first
    wr(ADDR_CTRL_ONE, 8'h5C);
    poll("internal clock", 8'h0C, 8'h04);
    wr(ADDR_CTRL_TWO, 8'h08);
    poll("lock lost", 8'h40, 8'h00);
    chk("fll off", {15'h0000, o_fll_enable}, 16'h0000);
    wr(ADDR_CTRL_TWO, 8'h00);
    tick(2);
    chk("fll running", {15'h0000, o_fll_enable}, 16'h0001);
    poll("bypassed lock", 8'h4C, 8'h44);
    wr(ADDR_CTRL_TWO, 8'h36);
    rchk("ctrl two", ADDR_CTRL_TWO, 8'h36);
    chk("osc pins", {13'h0000, o_osc_range, o_osc_gain, o_osc_enable}, 16'h0007);
    chk("bus div", {12'h000, o_bus_divisor}, 16'h0001);
    poll("osc not yet", 8'h02, 8'h00);
    poll("osc ready", 8'h02, 8'h02);
    wr(ADDR_CTRL_ONE, 8'h18);
    poll("status held", 8'h1C, 8'h14);
    poll("ref external", 8'h10, 8'h00);
    poll("lock dropped", 8'h40, 8'h00);
    tick(2);
    chk("ref divisor", {3'h0, o_ref_divisor}, 16'h0100);
    poll("fll clock", 8'h0C, 8'h00);
    tick(2);
    chk("clock status pin", {14'h0000, o_clock_status}, 16'h0000);
    poll("relock", 8'h40, 8'h40);
    chk("factor 512", {5'h00, o_fll_factor}, 16'h0200);
    wr(ADDR_CTRL_FOUR, 8'h01);
    tick(2);
    chk("factor 1024", {5'h00, o_fll_factor}, 16'h0400);
    poll("range unlock", 8'h40, 8'h00);
    poll("range relock", 8'h40, 8'h40);
    wr(ADDR_CTRL_FOUR, 8'h00);
    tick(2);
    chk("factor back", {5'h00, o_fll_factor}, 16'h0200);
    poll("back relock", 8'h40, 8'h40);
    // Trim at twice the final divider, then restore it
    wr(ADDR_CTRL_ONE, 8'h20);
    tick(2);
    chk("doubled divider", {3'h0, o_ref_divisor}, 16'h0200);
    // Trim word is register on top, fine bit below
    foreach (trim_tab[k]) begin
      wr(ADDR_TRIM, trim_tab[k][8:1]);
      wr(ADDR_STATUS, {7'h7F, trim_tab[k][0]});
      tick(2);
      chk("irc trim", {7'h00, o_irc_trim}, {7'h00, trim_tab[k]});
    end
    wr(ADDR_CTRL_ONE, 8'h18);
    tick(2);
    chk("divider restored", {3'h0, o_ref_divisor}, 16'h0100);
    poll("status bits kept", 8'h5F, 8'h43);
    rchk("irq all events", ADDR_IRQ_STAT, 8'h0F);
    chk("irq masked", {15'h0000, o_irq}, 16'h0000);
    wr(ADDR_IRQ_MASK, 8'h02);
    tick(2);
    chk("irq raised", {15'h0000, o_irq}, 16'h0001);
    wr(ADDR_IRQ_STAT, 8'h02);
    tick(2);
    chk("irq cleared", {15'h0000, o_irq}, 16'h0000);
    rchk("irq partial", ADDR_IRQ_STAT, 8'h0D);
    wr(ADDR_IRQ_STAT, 8'h0F);
    wr(ADDR_IRQ_MASK, 8'h01);
    rchk("irq empty", ADDR_IRQ_STAT, 8'h00);
    wr(ADDR_CTRL_FOUR, 8'h01);
    poll("lock for irq", 8'h40, 8'h40);
    tick(2);
    chk("lock irq", {15'h0000, o_irq}, 16'h0001);
    wr(3'h5, 8'hFF);
    rchk("unmapped", 3'h5, 8'h00);
    // Reset into debug boot takes the debug trim
    i_debug_boot <= 1'b1;
    i_rst_n <= 1'b0;
    tick(16);
    i_rst_n <= 1'b1;
    tick(7);
    chk("debug trim", {7'h00, o_irc_trim}, {7'h00, DEBUG_TRIM[8:0]});
    rchk("ctrl two again", ADDR_CTRL_TWO, RST_CTRL_TWO);
    conclude();
  end
endmodule
